//--- verilog/lars_defines.svh
// constants for the linear array readout sequencer
`ifndef LARS_DEFINES_SVH
`define LARS_DEFINES_SVH

`define LARS_CLK_NS        40
`define LARS_STAGES        9'h180
`define LARS_RESET_EDGES   9'h012
`define LARS_DONE_PAR      10'h181
`define LARS_DONE_SER      10'h301
`define LARS_PCLK_LAST     3'h7
`define LARS_PCLK_FALL     3'h3
`define LARS_INT_SER_NS    98000
`define LARS_INT_PAR_NS    50000
`define LARS_INT_SER_CYC   ((`LARS_INT_SER_NS + `LARS_CLK_NS - 1) / `LARS_CLK_NS)
`define LARS_INT_PAR_CYC   ((`LARS_INT_PAR_NS + `LARS_CLK_NS - 1) / `LARS_CLK_NS)
`define LARS_TIME_MAX      24'hFF_FFFF

`endif

//--- verilog/lars_pkg.sv
// types shared by both ends of the readout link
`default_nettype none
package lars_pkg;
    typedef logic [7:0]  lars_sample_t;
    typedef logic [8:0]  lars_stage_t;
    typedef logic [9:0]  lars_edge_t;
    typedef logic [11:0] lars_gap_t;
    typedef logic [23:0] lars_time_t;
    typedef enum logic [1:0] {
        LARS_IDLE,
        LARS_ARM,
        LARS_RUN
    } lars_ctl_state_t;
endpackage : lars_pkg
`default_nettype wire

//--- verilog/lars_link_if.sv
// pin-level link between controller and sensor array
`default_nettype none
interface lars_link_if;
    import lars_pkg::*;
    logic         pixel_clock_a;
    logic         pixel_clock_b;
    logic         start_pulse_in_a;
    logic         start_pulse_in_b;
    logic         sample_freeze_a;
    logic         sample_freeze_b;
    logic         chain_pulse_out_a;
    logic         chain_pulse_out_b;
    lars_sample_t pixel_level_out_a;
    lars_sample_t pixel_level_out_b;
    logic         pixel_level_oe_a;
    logic         pixel_level_oe_b;

    modport device (
        input  pixel_clock_a, pixel_clock_b,
        input  start_pulse_in_a, start_pulse_in_b,
        input  sample_freeze_a, sample_freeze_b,
        output chain_pulse_out_a, chain_pulse_out_b,
        output pixel_level_out_a, pixel_level_out_b,
        output pixel_level_oe_a, pixel_level_oe_b
    );
    modport ctrl (
        output pixel_clock_a, pixel_clock_b,
        output start_pulse_in_a, start_pulse_in_b,
        output sample_freeze_a, sample_freeze_b,
        input  chain_pulse_out_a, chain_pulse_out_b,
        input  pixel_level_out_a, pixel_level_out_b,
        input  pixel_level_oe_a, pixel_level_oe_b
    );
endinterface : lars_link_if
`default_nettype wire

//--- verilog/lars_section.sv
// one 384-stage section: shift sequencing, freeze and reset timing
`include "lars_defines.svh"
`default_nettype none
module lars_section
    import lars_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic         pclk,
    input  wire logic         start_in,
    input  wire logic         freeze_in,
    input  wire lars_sample_t sample_in,
    output logic              chain_out,
    output lars_sample_t      level_out,
    output logic              level_oe,
    output lars_stage_t       pixel_index,
    output logic              freeze_pulse,
    output logic              integ_reset
);
    logic        pclk_d_r;
    logic        freeze_d_r;
    logic        active_r;
    lars_stage_t pos_r;
    logic        integ_reset_r;
    lars_sample_t level_r;
    logic        oe_r;
    logic        step;

    ////////////////////////////////////////////////////////////////////////
    // only this section's own clock moves its sequence
    assign step = pclk & ~pclk_d_r;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pclk_d_r   <= 1'b0;
            freeze_d_r <= 1'b0;
        end
        else
        begin
            pclk_d_r   <= pclk;
            freeze_d_r <= freeze_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stage position; a new start always restarts at stage one
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            active_r <= 1'b0;
            pos_r    <= '0;
        end
        else if (step)
        begin
            if (start_in)
            begin
                active_r <= 1'b1;
                pos_r    <= 9'h001;
            end
            else if (active_r && pos_r == `LARS_STAGES)
            begin
                active_r <= 1'b0;
                pos_r    <= '0;
            end
            else if (active_r)
                pos_r <= pos_r + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // integrator reset spans the 18 clocks after capture
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            integ_reset_r <= 1'b0;
        else if (step && start_in)
            integ_reset_r <= 1'b1;
        else if (step && active_r && pos_r == `LARS_RESET_EDGES)
            integ_reset_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // held sample routed out; oe lags with the data so both line up
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            level_r <= '0;
            oe_r    <= 1'b0;
        end
        else
        begin
            level_r <= active_r ? sample_in : '0;
            oe_r    <= active_r;
        end
    end

    assign chain_out    = active_r && (pos_r == `LARS_STAGES);
    assign level_out    = level_r;
    assign level_oe     = oe_r;
    assign pixel_index  = active_r ? pos_r - 9'h001 : '0;
    assign freeze_pulse = freeze_in & ~freeze_d_r;
    assign integ_reset  = integ_reset_r;
endmodule : lars_section
`default_nettype wire

//--- verilog/lars_sensor_dev.sv
// two-section linear array: sequencing and integration timing
`include "lars_defines.svh"
`default_nettype none
module lars_sensor_dev
    import lars_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    lars_link_if.device       link,
    input  wire lars_sample_t sample_a,
    input  wire lars_sample_t sample_b,
    output lars_stage_t       pixel_index_a,
    output lars_stage_t       pixel_index_b,
    output logic              freeze_pulse_a,
    output logic              freeze_pulse_b,
    output logic              integ_reset_a,
    output logic              integ_reset_b,
    output logic              integrating_a,
    output logic              integrating_b,
    output lars_time_t        integ_time_a,
    output lars_time_t        integ_time_b
);
    logic        chain_a;
    logic        chain_b;
    logic [1:0]  frz;
    logic [1:0]  irst;
    logic [1:0]  irst_d_r;
    logic [1:0]  integ_r;
    lars_time_t  cnt_r  [2];
    lars_time_t  last_r [2];

    ////////////////////////////////////////////////////////////////////////
    // section a
    lars_section u_sec_a (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .pclk         (link.pixel_clock_a),
        .start_in     (link.start_pulse_in_a),
        .freeze_in    (link.sample_freeze_a),
        .sample_in    (sample_a),
        .chain_out    (chain_a),
        .level_out    (link.pixel_level_out_a),
        .level_oe     (link.pixel_level_oe_a),
        .pixel_index  (pixel_index_a),
        .freeze_pulse (frz[0]),
        .integ_reset  (irst[0])
    );

    ////////////////////////////////////////////////////////////////////////
    // section b; when start b is fed by chain a its 384th clock is
    // the 768th counted from the start of a
    lars_section u_sec_b (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .pclk         (link.pixel_clock_b),
        .start_in     (link.start_pulse_in_b),
        .freeze_in    (link.sample_freeze_b),
        .sample_in    (sample_b),
        .chain_out    (chain_b),
        .level_out    (link.pixel_level_out_b),
        .level_oe     (link.pixel_level_oe_b),
        .pixel_index  (pixel_index_b),
        .freeze_pulse (frz[1]),
        .integ_reset  (irst[1])
    );

    ////////////////////////////////////////////////////////////////////////
    // chain pulses leave the device for cascade or end of data
    assign link.chain_pulse_out_a = chain_a;
    assign link.chain_pulse_out_b = chain_b;

    assign freeze_pulse_a = frz[0];
    assign freeze_pulse_b = frz[1];
    assign integ_reset_a  = irst[0];
    assign integ_reset_b  = irst[1];

    ////////////////////////////////////////////////////////////////////////
    // integration window per section: opens when the reset ends,
    // closes on the freeze that disconnects every sample at once
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            irst_d_r <= '0;
        else
            irst_d_r <= irst;
    end

    for (genvar s = 0; s < 2; s++)
    begin : g_integ
        // freeze wins so a window never straddles two holds
        always_ff @(posedge clk_sys or negedge reset_n)
        begin
            if (!reset_n)
                integ_r[s] <= 1'b0;
            else if (frz[s])
                integ_r[s] <= 1'b0;
            else if (irst_d_r[s] && !irst[s])
                integ_r[s] <= 1'b1;
        end

        // counter saturates rather than wraps on very long exposures
        always_ff @(posedge clk_sys or negedge reset_n)
        begin
            if (!reset_n)
            begin
                cnt_r[s]  <= '0;
                last_r[s] <= '0;
            end
            else if (frz[s])
            begin
                last_r[s] <= cnt_r[s];
                cnt_r[s]  <= '0;
            end
            else if (integ_r[s] && cnt_r[s] != `LARS_TIME_MAX)
                cnt_r[s] <= cnt_r[s] + 24'h00_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // integration state toward the user side
    assign integrating_a = integ_r[0];
    assign integrating_b = integ_r[1];
    assign integ_time_a  = last_r[0];
    assign integ_time_b  = last_r[1];
endmodule : lars_sensor_dev
`default_nettype wire

//--- verilog/lars_controller.sv
// controller end: pixel clock, start/freeze pulses, pixel capture
`include "lars_defines.svh"
`default_nettype none
module lars_controller
    import lars_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire logic     reset_n,
    lars_link_if.ctrl     link,
    input  wire logic     go,
    input  wire logic     serial_mode,
    output logic          busy,
    output logic          frame_done,
    output logic          pix_valid_a,
    output lars_sample_t  pix_data_a,
    output lars_stage_t   pix_index_a,
    output logic          pix_valid_b,
    output lars_sample_t  pix_data_b,
    output lars_stage_t   pix_index_b
);
    lars_ctl_state_t state_r;
    logic [2:0]      phase_r;
    logic            pclk_r;
    logic            start_r;
    logic            serial_r;
    logic            done_r;
    lars_edge_t      edge_r;
    lars_gap_t       gap_r;
    logic            va_r;
    logic            vb_r;
    lars_sample_t    da_r;
    lars_sample_t    db_r;
    lars_stage_t     ia_r;
    lars_stage_t     ib_r;
    logic            rise_en;
    logic            fall_en;
    lars_edge_t      last_edge;

    assign rise_en   = (phase_r == `LARS_PCLK_LAST);
    assign fall_en   = (phase_r == `LARS_PCLK_FALL);
    assign last_edge = serial_r ? `LARS_DONE_SER : `LARS_DONE_PAR;

    ////////////////////////////////////////////////////////////////////////
    // free-running pixel clock divider, eight system clocks a period
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase_r <= '0;
            pclk_r  <= 1'b0;
        end
        else
        begin
            phase_r <= phase_r + 3'h1;
            if (rise_en)
                pclk_r <= 1'b1;
            else if (fall_en)
                pclk_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequence: start rises on a fall, is taken by one rise, drops
    // on the next fall; the run ends in the cycle the terminating clock rises
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r  <= LARS_IDLE;
            start_r  <= 1'b0;
            serial_r <= 1'b0;
            edge_r   <= '0;
            done_r   <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            case (state_r)
                LARS_IDLE:
                    if (go && gap_r == '0)
                    begin
                        serial_r <= serial_mode;
                        state_r  <= LARS_ARM;
                    end
                LARS_ARM:
                    if (fall_en)
                    begin
                        start_r <= 1'b1;
                        edge_r  <= '0;
                        state_r <= LARS_RUN;
                    end
                LARS_RUN:
                begin
                    if (fall_en)
                        start_r <= 1'b0;
                    if (rise_en)
                    begin
                        edge_r <= edge_r + 10'h001;
                        if (edge_r + 10'h001 == last_edge)
                        begin
                            done_r  <= 1'b1;
                            state_r <= LARS_IDLE;
                        end
                    end
                end
                default:
                    state_r <= LARS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // least spacing between starts, loaded as each start is raised
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            gap_r <= '0;
        else if (state_r == LARS_ARM && fall_en)
            gap_r <= serial_r ? 12'(`LARS_INT_SER_CYC)
                              : 12'(`LARS_INT_PAR_CYC);
        else if (gap_r != '0)
            gap_r <= gap_r - 12'h001;
    end

    ////////////////////////////////////////////////////////////////////////
    // capture pixels mid-period, when the level has long settled
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            va_r <= 1'b0;
            vb_r <= 1'b0;
            da_r <= '0;
            db_r <= '0;
            ia_r <= '0;
            ib_r <= '0;
        end
        else
        begin
            va_r <= fall_en && link.pixel_level_oe_a;
            vb_r <= fall_en && link.pixel_level_oe_b;
            if (state_r == LARS_ARM)
            begin
                ia_r <= '0;
                ib_r <= '0;
            end
            else
            begin
                if (va_r)
                    ia_r <= ia_r + 9'h001;
                if (vb_r)
                    ib_r <= ib_r + 9'h001;
            end
            if (fall_en && link.pixel_level_oe_a)
                da_r <= link.pixel_level_out_a;
            if (fall_en && link.pixel_level_oe_b)
                db_r <= link.pixel_level_out_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // board wiring: both sections share one clock rate, each own pin
    assign link.pixel_clock_a    = pclk_r;
    assign link.pixel_clock_b    = pclk_r;
    assign link.start_pulse_in_a = start_r;
    assign link.sample_freeze_a  = start_r;
    assign link.start_pulse_in_b = serial_r ? link.chain_pulse_out_a
                                            : start_r;
    assign link.sample_freeze_b  = start_r;

    assign busy        = (state_r != LARS_IDLE) || (gap_r != '0);
    assign frame_done  = done_r;
    assign pix_valid_a = va_r;
    assign pix_data_a  = da_r;
    assign pix_index_a = ia_r;
    assign pix_valid_b = vb_r;
    assign pix_data_b  = db_r;
    assign pix_index_b = ib_r;
endmodule : lars_controller
`default_nettype wire

//--- verification/lars_link_asserts.sv
// link checker: clock edge counts against chain, drive and start pins
`default_nettype none
module lars_link_asserts
    import lars_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         reset_n,
    input wire logic         pixel_clock_a,
    input wire logic         pixel_clock_b,
    input wire logic         start_pulse_in_a,
    input wire logic         start_pulse_in_b,
    input wire logic         sample_freeze_a,
    input wire logic         sample_freeze_b,
    input wire logic         chain_pulse_out_a,
    input wire logic         chain_pulse_out_b,
    input wire lars_sample_t pixel_level_out_a,
    input wire lars_sample_t pixel_level_out_b,
    input wire logic         pixel_level_oe_a,
    input wire logic         pixel_level_oe_b
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    logic       pclk_a_r;
    logic       pclk_b_r;
    logic       rise_a;
    logic       rise_b;
    lars_edge_t edge_a_r;
    lars_edge_t edge_b_r;

    // a rise is seen one cycle late, the same way the array sees it
    assign rise_a = pixel_clock_a & ~pclk_a_r;
    assign rise_b = pixel_clock_b & ~pclk_b_r;

    // edge 1 is the capture edge; wrapping while idle is harmless
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pclk_a_r <= 1'b0;
            pclk_b_r <= 1'b0;
            edge_a_r <= 10'h000;
            edge_b_r <= 10'h000;
        end
        else
        begin
            pclk_a_r <= pixel_clock_a;
            pclk_b_r <= pixel_clock_b;
            if (rise_a)
                edge_a_r <= start_pulse_in_a ? 10'h001 : edge_a_r + 10'h001;
            if (rise_b)
                edge_b_r <= start_pulse_in_b ? 10'h001 : edge_b_r + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_chain_a_edge;
        chain_pulse_out_a |-> edge_a_r == 10'h180;
    endproperty
    a_chain_a_edge: assert property (p_chain_a_edge)
        else $error("chain a high away from edge 384");
    property p_chain_b_edge;
        chain_pulse_out_b |-> edge_b_r == 10'h180;
    endproperty
    a_chain_b_edge: assert property (p_chain_b_edge)
        else $error("chain b high away from edge 384");
    property p_chain_a_len;
        $rose(chain_pulse_out_a) |-> chain_pulse_out_a[*8]
            ##1 !chain_pulse_out_a;
    endproperty
    a_chain_a_len: assert property (p_chain_a_len)
        else $error("chain a not one pixel period");
    property p_oe_a_on;
        $rose(pixel_level_oe_a) |-> edge_a_r == 10'h001;
    endproperty
    a_oe_a_on: assert property (p_oe_a_on)
        else $error("output a driven before capture");
    property p_oe_a_off;
        $fell(pixel_level_oe_a) |-> edge_a_r == 10'h181;
    endproperty
    a_oe_a_off: assert property (p_oe_a_off)
        else $error("output a released off edge 385");
    property p_oe_b_off;
        $fell(pixel_level_oe_b) |-> edge_b_r == 10'h181;
    endproperty
    a_oe_b_off: assert property (p_oe_b_off)
        else $error("output b released off its edge 385");
    property p_float;
        (!pixel_level_oe_a |-> pixel_level_out_a == 8'h00)
            and (!pixel_level_oe_b |-> pixel_level_out_b == 8'h00);
    endproperty
    a_float: assert property (p_float)
        else $error("level shown while not driven");
    property p_start_once;
        rise_a && start_pulse_in_a |-> ##8 !start_pulse_in_a;
    endproperty
    a_start_once: assert property (p_start_once)
        else $error("start a seen on two clock rises");
    property p_freeze_tie;
        sample_freeze_a == start_pulse_in_a
            && sample_freeze_b == start_pulse_in_a;
    endproperty
    a_freeze_tie: assert property (p_freeze_tie)
        else $error("freeze pins not tied to start a");
    property p_start_b_src;
        start_pulse_in_b |-> start_pulse_in_a || chain_pulse_out_a;
    endproperty
    a_start_b_src: assert property (p_start_b_src)
        else $error("start b from neither start a nor chain a");
endmodule : lars_link_asserts
`default_nettype wire

//--- verification/linear_array_readout_sequencer_bench.sv
// self-checking bench: both link ends joined, frames in each mode
`default_nettype none
module linear_array_readout_sequencer_bench;
    import lars_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic         clk_sys;
    logic         reset_n;
    logic         go;
    logic         serial_mode;
    logic         busy;
    logic         frame_done;
    logic         pix_valid_a;
    logic         pix_valid_b;
    lars_sample_t pix_data_a;
    lars_sample_t pix_data_b;
    lars_sample_t sample_a;
    lars_sample_t sample_b;
    lars_stage_t  pixel_index_a;
    lars_stage_t  pixel_index_b;
    lars_stage_t  pix_index_a;
    lars_stage_t  pix_index_b;
    lars_time_t   integ_time_a;
    logic         freeze_pulse_a;
    logic         freeze_pulse_b;
    logic         integ_reset_a;
    logic         integrating_a;
    logic         ca_q = 1'b0;
    logic         cb_q = 1'b0;
    logic         sa_q = 1'b0;
    logic         ra_q = 1'b0;
    int           num_errors = 0;
    int           num_checks = 0;
    int           cyc = 0;
    int           n_va, n_vb, n_start, n_done, rst_len;
    int           t_ca, t_cb, t_fa, t_fb;
    int           t_start = 0;
    int           t_prev = 0;
    int           t_re = 0;
    int           t_win = 0;

    lars_link_if link ();

    lars_sensor_dev lars_sensor_dev_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .link(link),
        .sample_a(sample_a), .sample_b(sample_b),
        .pixel_index_a(pixel_index_a), .pixel_index_b(pixel_index_b),
        .freeze_pulse_a(freeze_pulse_a), .freeze_pulse_b(freeze_pulse_b),
        .integ_reset_a(integ_reset_a), .integ_reset_b(),
        .integrating_a(integrating_a), .integrating_b(),
        .integ_time_a(integ_time_a), .integ_time_b()
    );

    lars_controller lars_controller_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .link(link),
        .go(go), .serial_mode(serial_mode), .busy(busy),
        .frame_done(frame_done),
        .pix_valid_a(pix_valid_a), .pix_data_a(pix_data_a),
        .pix_index_a(pix_index_a), .pix_valid_b(pix_valid_b),
        .pix_data_b(pix_data_b), .pix_index_b(pix_index_b)
    );

    lars_link_asserts lars_link_asserts_inst (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .pixel_clock_a(link.pixel_clock_a),
        .pixel_clock_b(link.pixel_clock_b),
        .start_pulse_in_a(link.start_pulse_in_a),
        .start_pulse_in_b(link.start_pulse_in_b),
        .sample_freeze_a(link.sample_freeze_a),
        .sample_freeze_b(link.sample_freeze_b),
        .chain_pulse_out_a(link.chain_pulse_out_a),
        .chain_pulse_out_b(link.chain_pulse_out_b),
        .pixel_level_out_a(link.pixel_level_out_a),
        .pixel_level_out_b(link.pixel_level_out_b),
        .pixel_level_oe_a(link.pixel_level_oe_a),
        .pixel_level_oe_b(link.pixel_level_oe_b)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_min(input int got, input int lo);
        num_checks++;
        if (got < lo)
        begin
            num_errors++;
            $display("[ERR] %0t spacing %0d below %0d", $time, got, lo);
        end
    endtask : check_min

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // one frame: go, wait for done, then that frame's own figures
    task automatic run_frame(input logic ser, input logic poke);
        int i;
        @(posedge clk_sys);
        n_va = 0;
        n_vb = 0;
        n_start = 0;
        n_done = 0;
        rst_len = 0;
        @(negedge clk_sys);
        serial_mode = ser;
        go = 1'b1;
        @(negedge clk_sys);
        go = 1'b0;
        // a poke in mid-frame must be ignored while busy
        for (i = 0; i < 8000 && frame_done !== 1'b1; i++)
        begin
            @(negedge clk_sys);
            go = poke && i == 1000;
        end
        repeat (20) @(negedge clk_sys);
        check_val(24'(n_va), 24'h00_0180);
        check_val(24'(n_vb), 24'h00_0180);
        check_val(24'(t_cb - t_ca), ser ? 24'h00_0C00 : 24'h0);
        check_val(24'(rst_len), 24'h00_0090);
        check_val(24'(t_fb - t_fa), 24'h0);
        check_val(24'(n_start), 24'h1);
        check_val(24'(n_done), 24'h1);
        check_val({22'h0, link.chain_pulse_out_b, link.pixel_level_oe_b},
                  24'h0);
        check_val({23'h0, busy}, 24'h0);
        if (t_prev > 0)
        begin
            check_min(t_start - t_prev, ser ? 2450 : 1250);
            check_val(integ_time_a, 24'(t_win));
        end
    endtask : run_frame

    ////////////////////////////////////////////////////////////////////////
    // 25 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // pixel values follow the index, so a slipped stage shows as bad data
    always @(negedge clk_sys)
    begin
        sample_a <= pixel_index_a[7:0] ^ 8'hA5;
        sample_b <= pixel_index_b[7:0] ^ 8'h3C;
    end

    // pin watch at the falling edge, where every output has settled
    always @(negedge clk_sys)
    begin
        cyc++;
        if (pix_valid_a === 1'b1)
        begin
            check_val(24'(pix_data_a), 24'(8'(n_va) ^ 8'hA5));
            check_val(24'(pix_index_a), 24'(n_va));
            n_va++;
        end
        if (pix_valid_b === 1'b1)
        begin
            check_val(24'(pix_data_b), 24'(8'(n_vb) ^ 8'h3C));
            check_val(24'(pix_index_b), 24'(n_vb));
            n_vb++;
        end
        if (integ_reset_a === 1'b1)
        begin
            check_val({23'h0, integrating_a}, 24'h0);
            rst_len++;
        end
        // integration window opens where the reset ends
        if (integ_reset_a === 1'b0 && ra_q)
            t_re = cyc;
        if (link.chain_pulse_out_a && !ca_q)
            t_ca = cyc;
        if (link.chain_pulse_out_b && !cb_q)
            t_cb = cyc;
        if (freeze_pulse_a === 1'b1)
            t_fa = cyc;
        if (freeze_pulse_b === 1'b1)
            t_fb = cyc;
        if (link.start_pulse_in_a && !sa_q)
        begin
            t_prev = t_start;
            t_start = cyc;
            t_win = cyc - t_re - 1;
            n_start++;
        end
        if (frame_done === 1'b1)
            n_done++;
        ca_q = link.chain_pulse_out_a;
        cb_q = link.chain_pulse_out_b;
        sa_q = link.start_pulse_in_a;
        ra_q = integ_reset_a;
        // ceiling about two and a half times the expected run of three frames
        if (cyc == 32'h0000_7530)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    // reset, then parallel, serial, and a parallel frame poked while busy
    initial
    begin
        reset_n = 1'b0;
        go = 1'b0;
        serial_mode = 1'b0;
        repeat (20) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        check_val({14'h0, link.pixel_level_oe_a, link.pixel_level_oe_b,
                   link.pixel_level_out_a}, 24'h0);
        run_frame(1'b0, 1'b0);
        run_frame(1'b1, 1'b0);
        run_frame(1'b0, 1'b1);
        tally_and_finish();
    end
endmodule : linear_array_readout_sequencer_bench
`default_nettype wire
